// File: logic/cpw_pkg.sv
// package: register map, field layout, reset values and mode codes
package cpw_pkg;

  // register byte offsets on the avalon-mm slave
  localparam logic [5:0] OFS_CTRL = 6'h00;
  localparam logic [5:0] OFS_DUTY_LO = 6'h04;
  localparam logic [5:0] OFS_SHADOW = 6'h08;
  localparam logic [5:0] OFS_PERIOD = 6'h0c;
  localparam logic [5:0] OFS_TMR = 6'h10;
  localparam logic [5:0] OFS_TCTRL = 6'h14;
  localparam logic [5:0] OFS_STAT = 6'h18;
  localparam logic [5:0] OFS_DIR = 6'h1c;

  // unit_control fields
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_DC_LSB = 4;
  localparam int CTRL_W = 6;

  // period_timer_control fields
  localparam int TCTRL_PS_LSB = 0;
  localparam int TCTRL_ON_BIT = 2;
  localparam int TCTRL_W = 3;

  // status and pin direction fields
  localparam int STAT_FLAG_BIT = 0;
  localparam int DIR_IN_BIT = 0;

  // reset values
  localparam logic [5:0] RST_CTRL = 6'h00;
  localparam logic [7:0] RST_DUTY_LO = 8'h00;
  localparam logic [7:0] RST_SHADOW = 8'h00;
  localparam logic [7:0] RST_PERIOD = 8'hff;
  localparam logic [7:0] RST_TMR = 8'h00;
  localparam logic [2:0] RST_TCTRL = 3'h0;
  localparam logic RST_DIR = 1'b1;

  // unit_mode_field codes
  localparam logic [3:0] MODE_OFF = 4'h0;
  localparam logic [3:0] MODE_RSV1 = 4'h1;
  localparam logic [3:0] MODE_TOGGLE = 4'h2;
  localparam logic [3:0] MODE_RSV3 = 4'h3;
  localparam logic [3:0] MODE_CAP_FALL = 4'h4;
  localparam logic [3:0] MODE_CAP_RISE = 4'h5;
  localparam logic [3:0] MODE_CAP_R4 = 4'h6;
  localparam logic [3:0] MODE_CAP_R16 = 4'h7;
  localparam logic [3:0] MODE_CMP_SET = 4'h8;
  localparam logic [3:0] MODE_CMP_CLR = 4'h9;
  localparam logic [3:0] MODE_SWI = 4'ha;
  localparam logic [3:0] MODE_SEV = 4'hb;

  // prescaler selection codes
  localparam logic [1:0] PS_DIV1 = 2'h0;
  localparam logic [1:0] PS_DIV4 = 2'h1;

  // capture prescaler terminal counts
  localparam logic [3:0] CAP_LAST4 = 4'h3;
  localparam logic [3:0] CAP_LAST16 = 4'hf;

  // time base step from the prescaler block
  typedef struct packed {
    logic tick;
    logic [1:0] low2;
  } cpw_tb_t;

endpackage : cpw_pkg

// File: logic/cpw_timebase.sv
// period timer clock phase and prescaler giving the time base low bits
`timescale 1ns/1ps
module cpw_timebase
  import cpw_pkg::*;
(
  input logic clk_sys,
  input logic nrst,
  input logic run,
  input logic [1:0] ps_sel,
  output cpw_tb_t tb
);

  logic [1:0] q_ff;
  logic [3:0] psc_ff;
  logic q_last;
  logic ps_end;

  assign q_last = (q_ff == 2'h3);
  assign ps_end = (ps_sel == PS_DIV1) ||
                  (ps_sel == PS_DIV4 && psc_ff[1:0] == 2'h3) ||
                  (ps_sel[1] && psc_ff == 4'hf);
  assign tb.tick = run && q_last && ps_end;
  // clock phase at 1:1, prescaler bits otherwise
  assign tb.low2 = (ps_sel == PS_DIV1) ? q_ff :
                   (ps_sel == PS_DIV4) ? psc_ff[1:0] : psc_ff[3:2];

  // frozen while not running so the time base resumes where it stopped
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      q_ff <= 2'h0;
      psc_ff <= 4'h0;
    end else if (run) begin
      q_ff <= q_ff + 2'h1;
      psc_ff <= q_last ? psc_ff + 4'h1 : psc_ff;
    end
  end

  tick_low_a: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    tb.tick |-> tb.low2 == 2'h3)
    else $error("timer step not at end of low bits");
  phase_sel_a: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    ps_sel == PS_DIV1 |-> tb.low2 == q_ff)
    else $error("low bits not clock phase at 1:1");

endmodule : cpw_timebase

// File: logic/cpw_unit.sv
// capture/compare/pwm unit with its period timer and avalon-mm slave
//
// Decided for this implementation: the address map and register access over Avalon-MM.
`timescale 1ns/1ps
// Function
// - duty double buffered in shadow and latch
// - 10-bit time base: timer plus two bits
// - low bits: clock phase at 1:1, else prescaler
// - pin cleared when time base equals duty
// - resolution grows with period limit, 10 at 255
// - duty beyond period leaves pin unchanged
// - sleep freezes timer, state and pin
// - reset restores registers, pin as input
// - control bits 7-6 read zero
// - control bits 5-4 are duty lsbs
// - mode 0000 off and reset, 0001/0011 nothing
// - mode 0010 toggles output on match
// - capture edge modes fall, rise, 4th, 16th
// - 1000 sets, 1001 clears, both flag
// - 1010 only sets flag
// - 1011 trigger, flag, converter start
// - period end: clear timer, load duty, set pin unless loaded duty is zero
// - duty is low register then two lsbs
// - shadow read-only in pwm mode
module cpw_unit
  import cpw_pkg::*;
(
  input logic clk_sys,
  input logic nrst,
  input logic [5:0] avs_address,
  input logic avs_read,
  input logic avs_write,
  input logic [31:0] avs_writedata,
  input logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input logic sleep_i,
  input logic cmp_match_i,
  input logic adc_enable_i,
  input logic cap_pin_i,
  output logic pin_o,
  output logic pin_oe_n,
  output logic match_flag_o,
  output logic capt_strobe_o,
  output logic sev_trig_o,
  output logic adc_start_o
);

  logic [CTRL_W-1:0] ctrl_ff;
  logic [7:0] duty_lo_ff;
  logic [7:0] shadow_ff;
  logic [1:0] latch_ff;
  logic [7:0] period_ff;
  logic [7:0] tmr_ff;
  logic [TCTRL_W-1:0] tctrl_ff;
  logic flag_ff;
  logic dir_ff;
  logic pin_ff;
  logic ack_ff;
  logic [31:0] rdata_ff;
  logic [2:0] cap_sync_ff;
  logic [3:0] cap_cnt_ff;
  logic strobe_ff;
  logic sev_ff;
  logic adc_ff;
  logic wrap_d_ff; // set lags a step, as the clear does, for exact width
  logic [7:0] nxt_tmr;
  logic nxt_pin;
  logic [3:0] nxt_cap_cnt;
  logic [31:0] nxt_rdata;
  cpw_tb_t tb;

  // bus decode
  wire req = avs_read | avs_write;
  wire rd_first = avs_read & ~ack_ff;
  wire wr_go = avs_write & ack_ff & avs_byteenable[0];
  wire mapped = ~avs_address[5] & (avs_address[1:0] == 2'h0);
  wire [5:0] ofs = {avs_address[5:2], 2'h0};
  wire hit_ctrl = mapped & (ofs == OFS_CTRL);
  wire hit_duty = mapped & (ofs == OFS_DUTY_LO);
  wire hit_shadow = mapped & (ofs == OFS_SHADOW);
  wire hit_period = mapped & (ofs == OFS_PERIOD);
  wire hit_tmr = mapped & (ofs == OFS_TMR);
  wire hit_tctrl = mapped & (ofs == OFS_TCTRL);
  wire hit_stat = mapped & (ofs == OFS_STAT);
  wire hit_dir = mapped & (ofs == OFS_DIR);
  wire [7:0] wd = avs_writedata[7:0];

  // mode decode
  wire [3:0] mode = ctrl_ff[CTRL_MODE_LSB +: 4];
  wire [1:0] dc_lsb = ctrl_ff[CTRL_DC_LSB +: 2];
  wire is_off = (mode == MODE_OFF);
  wire is_pwm = (mode[3:2] == 2'b11);
  wire is_cap = (mode[3:2] == 2'b01);
  wire is_cmp = (mode[3:2] == 2'b10) | (mode == MODE_TOGGLE);
  wire awake = ~sleep_i;

  // period timer and pwm time base
  wire tmr_run = tctrl_ff[TCTRL_ON_BIT] & awake;
  wire tick = tb.tick;
  wire wrap = tick & (tmr_ff == period_ff);
  wire [9:0] duty = {duty_lo_ff, dc_lsb};
  wire [9:0] tbase = {tmr_ff, tb.low2};
  // no match when duty exceeds the period, so the pin is simply left set
  wire pwm_match = is_pwm & (tbase == {shadow_ff, latch_ff});

  // compare events, only from the selected compare modes
  wire cmp_ev = cmp_match_i & awake & is_cmp;
  wire cmp_flag = cmp_ev & (mode != MODE_TOGGLE);
  wire sev_ev = cmp_ev & (mode == MODE_SEV);

  // capture edges taken from the synchronised pin only
  wire rise = cap_sync_ff[1] & ~cap_sync_ff[2];
  wire fall = ~cap_sync_ff[1] & cap_sync_ff[2];
  wire cap_ev = awake & is_cap & (
    (mode == MODE_CAP_FALL) ? fall :
    (mode == MODE_CAP_RISE) ? rise :
    (mode == MODE_CAP_R4) ? rise & (cap_cnt_ff == CAP_LAST4) :
    rise & (cap_cnt_ff == CAP_LAST16));

  // status flag: a new event beats a clear in the same cycle
  wire flag_set = cmp_flag | cap_ev;
  wire flag_clr = wr_go & hit_stat & wd[STAT_FLAG_BIT];

  // the unit owns the pin only in output compare and pwm modes
  wire drives = is_pwm | (mode == MODE_TOGGLE) |
                (mode == MODE_CMP_SET) | (mode == MODE_CMP_CLR);

  cpw_timebase u_timebase (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .run(tmr_run),
    .ps_sel(tctrl_ff[TCTRL_PS_LSB +: 2]),
    .tb(tb)
  );

  assign avs_waitrequest = req & ~ack_ff;
  assign avs_readdata = rdata_ff;
  assign pin_o = pin_ff;
  assign pin_oe_n = dir_ff | ~drives;
  assign match_flag_o = flag_ff;
  assign capt_strobe_o = strobe_ff;
  assign sev_trig_o = sev_ff;
  assign adc_start_o = adc_ff;

  always_comb begin
    nxt_tmr = tmr_ff;
    if (wr_go & hit_tmr) begin
      nxt_tmr = wd;
    end else if (wrap) begin
      nxt_tmr = 8'h00;
    end else if (tick) begin
      nxt_tmr = tmr_ff + 8'h01;
    end
  end

  always_comb begin
    nxt_pin = pin_ff;
    if (is_off) begin
      nxt_pin = 1'b0;
    end else if (sleep_i) begin
      nxt_pin = pin_ff;
    end else if (is_pwm) begin
      if (wrap_d_ff) begin
        nxt_pin = ({shadow_ff, latch_ff} != 10'h000);
      end else if (pwm_match) begin
        nxt_pin = 1'b0;
      end
    end else if (cmp_ev) begin
      case (mode)
        MODE_TOGGLE: nxt_pin = ~pin_ff;
        MODE_CMP_SET: nxt_pin = 1'b1;
        MODE_CMP_CLR: nxt_pin = 1'b0;
        default: nxt_pin = pin_ff;
      endcase
    end
  end

  always_comb begin
    nxt_cap_cnt = cap_cnt_ff;
    if (~is_cap) begin
      nxt_cap_cnt = 4'h0;
    end else if (awake & rise) begin
      if (mode == MODE_CAP_R4 && cap_cnt_ff == CAP_LAST4) begin
        nxt_cap_cnt = 4'h0;
      end else begin
        nxt_cap_cnt = cap_cnt_ff + 4'h1;
      end
    end
  end

  // reserved control bits are not stored, so they read as zero
  always_comb begin
    nxt_rdata = 32'h0000_0000;
    if (hit_ctrl) nxt_rdata[CTRL_W-1:0] = ctrl_ff;
    if (hit_duty) nxt_rdata[7:0] = duty_lo_ff;
    if (hit_shadow) nxt_rdata[7:0] = shadow_ff;
    if (hit_period) nxt_rdata[7:0] = period_ff;
    if (hit_tmr) nxt_rdata[7:0] = tmr_ff;
    if (hit_tctrl) nxt_rdata[TCTRL_W-1:0] = tctrl_ff;
    if (hit_stat) nxt_rdata[STAT_FLAG_BIT] = flag_ff;
    if (hit_dir) nxt_rdata[DIR_IN_BIT] = dir_ff;
  end

  // one wait state: answer on the second edge of every request
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      ack_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
    end else begin
      ack_ff <= req & ~ack_ff;
      rdata_ff <= rd_first ? nxt_rdata : rdata_ff;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      ctrl_ff <= RST_CTRL;
      duty_lo_ff <= RST_DUTY_LO;
      period_ff <= RST_PERIOD;
      tctrl_ff <= RST_TCTRL;
      dir_ff <= RST_DIR;
    end else if (wr_go) begin
      ctrl_ff <= hit_ctrl ? wd[CTRL_W-1:0] : ctrl_ff;
      duty_lo_ff <= hit_duty ? wd : duty_lo_ff;
      period_ff <= hit_period ? wd : period_ff;
      tctrl_ff <= hit_tctrl ? wd[TCTRL_W-1:0] : tctrl_ff;
      dir_ff <= hit_dir ? wd[DIR_IN_BIT] : dir_ff;
    end
  end

  // duty reaches the comparator only at a period boundary
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      shadow_ff <= RST_SHADOW;
      latch_ff <= 2'h0;
    end else if (is_pwm & wrap) begin
      {shadow_ff, latch_ff} <= duty;
    end else begin
      if (wr_go & hit_shadow & ~is_pwm) shadow_ff <= wd;
      if (is_off) latch_ff <= 2'h0;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      tmr_ff <= RST_TMR;
      pin_ff <= 1'b0;
      flag_ff <= 1'b0;
      cap_sync_ff <= 3'h0;
      cap_cnt_ff <= 4'h0;
      strobe_ff <= 1'b0;
      sev_ff <= 1'b0;
      adc_ff <= 1'b0;
      wrap_d_ff <= 1'b0;
    end else begin
      tmr_ff <= nxt_tmr;
      pin_ff <= nxt_pin;
      flag_ff <= flag_set | (flag_ff & ~flag_clr);
      cap_sync_ff <= {cap_sync_ff[1:0], cap_pin_i};
      cap_cnt_ff <= nxt_cap_cnt;
      strobe_ff <= cap_ev;
      sev_ff <= sev_ev;
      adc_ff <= sev_ev & adc_enable_i;
      wrap_d_ff <= sleep_i ? wrap_d_ff : (is_pwm & wrap);
    end
  end

  shadow_hold_a: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    is_pwm && $past(is_pwm) && $changed(shadow_ff) |-> $past(wrap))
    else $error("shadow duty changed inside a period");
  match_clear_a: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    pwm_match && !wrap_d_ff && awake |=> !pin_ff)
    else $error("pin not cleared on duty match");
  wrap_load_a: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    is_pwm && wrap && !(wr_go && hit_tmr) |=>
      tmr_ff == 8'h00 && {shadow_ff, latch_ff} == $past(duty))
    else $error("period end did not reload");
  period_set_a: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    is_pwm && wrap_d_ff && awake |=>
      pin_ff == ($past(shadow_ff) != 8'h00 || $past(latch_ff) != 2'h0))
    else $error("pin not set at period start");
  sleep_freeze_a: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    sleep_i && !wr_go && !is_off |=> $stable(tmr_ff) && $stable(pin_ff))
    else $error("state moved during sleep");
  ctrl_rsvd_a: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    rd_first && hit_ctrl |=> avs_readdata[31:6] == 26'h0)
    else $error("reserved control bits not zero");
  off_reset_a: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    is_off && !(wr_go && hit_ctrl) |=>
      !pin_ff && cap_cnt_ff == 4'h0 && pin_oe_n)
    else $error("off mode did not reset unit");
  toggle_a: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    mode == MODE_TOGGLE && cmp_match_i && awake |=>
      pin_ff != $past(pin_ff))
    else $error("toggle mode did not invert");
  cap16_a: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    mode == MODE_CAP_R16 && cap_ev |=> strobe_ff && cap_cnt_ff == 4'h0)
    else $error("sixteenth edge capture wrong");
  cmp_flag_a: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    cmp_match_i && awake && mode[3:2] == 2'b10 |=> flag_ff)
    else $error("match flag not set");
  swi_pin_a: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    mode == MODE_SWI |-> pin_oe_n)
    else $error("pin driven in flag-only mode");
  sev_adc_a: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    sev_ev |=> sev_trig_o && adc_start_o == $past(adc_enable_i))
    else $error("trigger or converter start wrong");
  shadow_ro_a: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    is_pwm && wr_go && hit_shadow && !wrap |=> $stable(shadow_ff))
    else $error("shadow written in pwm mode");

  wrap_c: cover property (@(posedge clk_sys) disable iff (!nrst)
    is_pwm && wrap && duty != 10'h000);
  match_c: cover property (@(posedge clk_sys) disable iff (!nrst)
    pin_ff && pwm_match);
  cap_c: cover property (@(posedge clk_sys) disable iff (!nrst)
    mode == MODE_CAP_R4 && cap_ev);
  sev_c: cover property (@(posedge clk_sys) disable iff (!nrst)
    sev_ev && adc_enable_i);

endmodule : cpw_unit

// File: dv/cpw_load_model.sv
// load on the unit output pin: resolves the line and times each period
`timescale 1ns/1ps
module cpw_load_model (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic pin_o,
  input wire logic pin_oe_n,
  output logic pin_lvl,
  output logic [15:0] per_len_ff
);
  logic lvl_ff;
  logic [15:0] run_ff;
  // a released pin is sunk to ground by the load, never left floating
  assign pin_lvl = pin_oe_n ? 1'b0 : pin_o;
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      lvl_ff <= 1'b0;
      run_ff <= 16'h0;
      per_len_ff <= 16'h0;
    end else begin
      lvl_ff <= pin_lvl;
      run_ff <= (pin_lvl && !lvl_ff) ? 16'h1 : run_ff + 16'h1;
      if (pin_lvl && !lvl_ff) begin
        per_len_ff <= run_ff;
      end
    end
  end
endmodule : cpw_load_model

// File: dv/cpw_unit_tb_top.sv
// self-checking bench for the capture/compare/pwm unit
`timescale 1ns/1ps
module cpw_unit_tb_top
  import cpw_pkg::*;
();
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  logic [5:0] avs_address = 6'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'hf;
  logic sleep_i = 1'b0;
  logic cmp_match_i = 1'b0;
  logic adc_enable_i = 1'b0;
  logic cap_pin_i = 1'b0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest, pin_o, pin_oe_n, match_flag_o;
  logic capt_strobe_o, sev_trig_o, adc_start_o, pin_lvl;
  logic [15:0] per_len;
  logic [7:0] rd;
  int err_count = 0;
  int checked = 0;
  int n_capt = 0;

  always #50 clk_sys = ~clk_sys;
  always @(posedge clk_sys) if (capt_strobe_o === 1'b1) n_capt++;

  cpw_unit uut (.clk_sys(clk_sys), .nrst(nrst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .sleep_i(sleep_i), .cmp_match_i(cmp_match_i),
    .adc_enable_i(adc_enable_i), .cap_pin_i(cap_pin_i), .pin_o(pin_o),
    .pin_oe_n(pin_oe_n), .match_flag_o(match_flag_o),
    .capt_strobe_o(capt_strobe_o), .sev_trig_o(sev_trig_o),
    .adc_start_o(adc_start_o));
  cpw_load_model load (.clk_sys(clk_sys), .nrst(nrst), .pin_o(pin_o),
    .pin_oe_n(pin_oe_n), .pin_lvl(pin_lvl), .per_len_ff(per_len));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
      err_count++;
    end
  endtask : chk

  // one avalon transfer; request held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [5:0] a,
                     input logic [7:0] d);
    @(posedge clk_sys);
    avs_address <= a;
    avs_writedata <= {24'h0, d};
    avs_write <= wr;
    avs_read <= ~wr;
    // no fixed latency assumed; only the watchdog ends a hung wait
    do begin
      @(posedge clk_sys);
    end while (avs_waitrequest !== 1'b0);
    rd = avs_readdata[7:0];
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask : bus

  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
  endtask : wr

  task automatic rdchk(input logic [5:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    chk(rd, e);
  endtask : rdchk

  task automatic t_reset();
    rdchk(OFS_CTRL, {2'b00, RST_CTRL});
    rdchk(OFS_DUTY_LO, RST_DUTY_LO);
    rdchk(OFS_SHADOW, RST_SHADOW);
    rdchk(OFS_PERIOD, RST_PERIOD);
    rdchk(OFS_TMR, RST_TMR);
    rdchk(OFS_TCTRL, {5'h0, RST_TCTRL});
    rdchk(OFS_DIR, {7'h0, RST_DIR});
    rdchk(OFS_STAT, 8'h00);
    rdchk(6'h20, 8'h00);
    chk(pin_oe_n, 1'b1);
    $display("reset test done");
  endtask : t_reset

  task automatic t_ctrl();
    avs_byteenable <= 4'he;
    wr(OFS_DUTY_LO, 8'haa);
    avs_byteenable <= 4'hf;
    rdchk(OFS_DUTY_LO, 8'h00);
    wr(OFS_CTRL, 8'hff);
    rdchk(OFS_CTRL, 8'h3f);
    wr(OFS_SHADOW, 8'h55);
    rdchk(OFS_SHADOW, 8'h00);
    $display("control test done");
  endtask : t_ctrl

  // counts high cycles over four whole periods after two to settle
  task automatic t_pwm(input logic [1:0] ps, input logic [7:0] dlo,
                       input logic [1:0] dc, input int per, input int hi4);
    int h;
    wr(OFS_CTRL, {2'b00, dc, 4'hc});
    wr(OFS_DUTY_LO, dlo);
    wr(OFS_PERIOD, 8'h03);
    wr(OFS_TMR, 8'h00);
    wr(OFS_DIR, 8'h00);
    wr(OFS_TCTRL, {6'h01, ps});
    repeat (2 * per) @(posedge clk_sys);
    h = 0;
    repeat (4 * per) begin
      @(negedge clk_sys);
      if (pin_lvl === 1'b1) h++;
    end
    chk(h, hi4);
    if (hi4 != 0 && hi4 != 4 * per) chk(per_len, per);
    rdchk(OFS_SHADOW, dlo);
    wr(OFS_TCTRL, 8'h00);
    $display("pwm test done");
  endtask : t_pwm

  task automatic t_sleep();
    logic [7:0] v;
    logic p;
    wr(OFS_DUTY_LO, 8'h02);
    wr(OFS_TCTRL, 8'h04);
    repeat (7) @(posedge clk_sys);
    sleep_i <= 1'b1;
    @(negedge clk_sys);
    p = pin_lvl;
    bus(1'b0, OFS_TMR, 8'h00);
    v = rd;
    repeat (20) @(posedge clk_sys);
    chk(pin_lvl, p);
    rdchk(OFS_TMR, v);
    sleep_i <= 1'b0;
    repeat (10) @(posedge clk_sys);
    bus(1'b0, OFS_TMR, 8'h00);
    chk(rd !== v, 1'b1);
    wr(OFS_TCTRL, 8'h00);
    $display("sleep test done");
  endtask : t_sleep

  task automatic hit(input logic [3:0] m);
    wr(OFS_CTRL, {4'h0, m});
    @(posedge clk_sys);
    cmp_match_i <= 1'b1;
    @(posedge clk_sys);
    cmp_match_i <= 1'b0;
    @(negedge clk_sys);
  endtask : hit

  task automatic t_cmp();
    @(posedge clk_sys);
    adc_enable_i <= 1'b1;
    hit(MODE_CMP_SET);
    chk({pin_o, match_flag_o}, 2'b11);
    wr(OFS_STAT, 8'h01);
    @(negedge clk_sys);
    chk(match_flag_o, 1'b0);
    hit(MODE_CMP_CLR);
    chk({pin_o, match_flag_o}, 2'b01);
    hit(MODE_TOGGLE);
    chk(pin_o, 1'b1);
    hit(MODE_TOGGLE);
    chk(pin_o, 1'b0);
    wr(OFS_STAT, 8'h01);
    hit(MODE_SWI);
    chk({pin_oe_n, pin_o, match_flag_o}, 3'b101);
    wr(OFS_STAT, 8'h01);
    hit(MODE_SEV);
    chk({sev_trig_o, adc_start_o, match_flag_o}, 3'b111);
    rdchk(OFS_STAT, 8'h01);
    hit(MODE_CMP_SET);
    wr(OFS_CTRL, 8'h00);
    // pin latch clears one edge after the mode write lands
    repeat (2) @(negedge clk_sys);
    chk({pin_oe_n, pin_o}, 2'b10);
    wr(OFS_STAT, 8'h01);
    hit(MODE_RSV1);
    chk({pin_oe_n, match_flag_o}, 2'b10);
    hit(MODE_RSV3);
    chk({pin_oe_n, match_flag_o}, 2'b10);
    $display("compare test done");
  endtask : t_cmp

  task automatic t_cap();
    int e[4] = '{16, 16, 4, 1};
    for (int i = 0; i < 4; i++) begin
      wr(OFS_CTRL, 8'h00);
      wr(OFS_CTRL, 8'(MODE_CAP_FALL) + 8'(i));
      n_capt = 0;
      repeat (16) begin
        repeat (4) @(posedge clk_sys);
        cap_pin_i <= 1'b1;
        repeat (4) @(posedge clk_sys);
        cap_pin_i <= 1'b0;
      end
      repeat (6) @(posedge clk_sys);
      chk(n_capt, e[i]);
    end
    $display("capture test done");
  endtask : t_cap

  task automatic test_done();
    $display("comparisons %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : test_done

  initial begin
    repeat (2) @(posedge clk_sys);
    nrst <= 1'b1;
    t_reset();
    t_ctrl();
    t_pwm(PS_DIV1, 8'h02, 2'b01, 16, 36);
    t_pwm(PS_DIV4, 8'h02, 2'b01, 64, 144);
    t_pwm(2'h2, 8'h02, 2'b01, 256, 576);
    t_pwm(PS_DIV1, 8'h00, 2'b00, 16, 0);
    t_pwm(PS_DIV1, 8'h10, 2'b00, 16, 64);
    t_sleep();
    t_cmp();
    t_cap();
    test_done();
  end

  // whole run is a few thousand cycles; this allows ample margin
  initial begin
    #2000000;
    err_count++;
    test_done();
  end
endmodule : cpw_unit_tb_top
